// ### verilog/slrc_top.sv
// sleep state sequencer, reset pin filter and pin tristate control behind an ahb-lite slave
`timescale 1ns/1ps
module slrc_top import slrc_pkg::*; #(
    parameter int PORT_WIDTH = 6
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sleep_instr,
    input wire logic irq_pending,
    input wire logic reset_pin_as_io,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic reset_pin_pullup,
    output logic chip_reset_req,
    input wire logic [PORT_WIDTH-1:0] general_port_pins_in,
    output logic [PORT_WIDTH-1:0] general_port_pins_out,
    output logic [PORT_WIDTH-1:0] general_port_pins_oe,
    output logic [PORT_WIDTH-1:0] general_port_pins_pullup,
    output slrc_gate_type run_gates
);
    // pin inputs read back from bit 24 up, so more than six would run into the reset pin bits
    if (PORT_WIDTH < 1 || PORT_WIDTH > 6) begin : gen_width_check
        $error("slrc_top: PORT_WIDTH must be 1 to 6");
    end

    localparam int RST_CNT_W = $clog2(SLRC_RST_MIN_CYCLES + 1);
    localparam logic [RST_CNT_W-1:0] RST_CNT_MAX = RST_CNT_W'(SLRC_RST_MIN_CYCLES);

    // true when a captured index names the given register
    function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] reg_idx);
        idx_hit = (idx == reg_idx);
    endfunction

    logic [7:0] core_control_reg;
    logic [7:0] reset_cause_flags_reg;
    logic [PORT_WIDTH-1:0] port_out_reg;
    logic [PORT_WIDTH-1:0] port_dir_reg;
    logic rst_pin_out_reg;
    logic rst_pin_dir_reg;
    logic rst_io_reg;
    logic strap_done_reg;
    slrc_state_type state_reg;
    slrc_state_type state_next;
    slrc_aphase_type aphase_reg;
    logic dphase_reg;
    logic [RST_CNT_W-1:0] rst_cnt_reg;
    logic rst_req_reg;
    logic addr_valid;
    logic wr_en;
    logic [31:0] rd_value;
    logic [1:0] sleep_sel;
    logic rst_pin_low;
    logic [7:0] wbyte;

    assign hreadyout = 1'b1; // zero wait states, every access completes at once
    assign hresp = 1'b0;
    assign addr_valid = hsel && hready && (htrans == SLRC_HTRANS_NONSEQ);
    assign wr_en = dphase_reg && aphase_reg.write;
    assign wbyte = hwdata[7:0];
    assign sleep_sel = {core_control_reg[SLRC_CC_SEL_HI], core_control_reg[SLRC_CC_SEL_LO]};

    // capture address phase; the word index comes from haddr[9:2]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aphase_reg <= '0;
            dphase_reg <= 1'b0;
        end else begin
            dphase_reg <= addr_valid;
            if (addr_valid) begin
                aphase_reg.write <= hwrite;
                aphase_reg.index <= haddr[9:2];
            end
        end
    end

    // read mux, unmapped words read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        if (idx_hit(haddr[9:2], SLRC_IDX_CORE_CTRL)) begin
            rd_value[7:0] = core_control_reg;
        end else if (idx_hit(haddr[9:2], SLRC_IDX_RESET_CAUSE)) begin
            rd_value[7:0] = reset_cause_flags_reg;
        end else if (idx_hit(haddr[9:2], SLRC_IDX_PIN_CTRL)) begin
            rd_value[SLRC_PC_OUT_LSB +: PORT_WIDTH] = port_out_reg;
            rd_value[SLRC_PC_DIR_LSB +: PORT_WIDTH] = port_dir_reg;
            rd_value[SLRC_PC_RST_OUT] = rst_pin_out_reg;
            rd_value[SLRC_PC_RST_DIR] = rst_pin_dir_reg;
            rd_value[SLRC_PC_IN_LSB +: PORT_WIDTH] = general_port_pins_in;
            rd_value[SLRC_PC_RST_IN] = reset_pin_in;
            rd_value[SLRC_PC_RST_IO] = rst_io_reg;
        end else if (idx_hit(haddr[9:2], SLRC_IDX_SLEEP_STAT)) begin
            rd_value[1:0] = state_reg;
        end
    end

    // read data is latched at the address phase so it stands from a flop in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            hrdata <= rd_value;
        end
    end

    // core_control: sleep enable and mode select live here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_control_reg <= SLRC_CC_RESET;
        end else if (wr_en && idx_hit(aphase_reg.index, SLRC_IDX_CORE_CTRL)) begin
            core_control_reg <= wbyte & SLRC_CC_WMASK;
        end
    end

    // reset cause: external flag set by the filtered pin, cleared by writing zero; set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_cause_flags_reg <= SLRC_RC_RESET;
        end else begin
            if (wr_en && idx_hit(aphase_reg.index, SLRC_IDX_RESET_CAUSE)) begin
                reset_cause_flags_reg[SLRC_RC_EXT] <= reset_cause_flags_reg[SLRC_RC_EXT] & wbyte[SLRC_RC_EXT];
                reset_cause_flags_reg[SLRC_RC_POWER] <= reset_cause_flags_reg[SLRC_RC_POWER] & wbyte[SLRC_RC_POWER];
            end
            if (rst_req_reg) begin
                reset_cause_flags_reg[SLRC_RC_EXT] <= 1'b1;
            end
        end
    end

    // pin drive registers for the general port and the reset pin in io use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_out_reg <= '0;
            port_dir_reg <= '0;
            rst_pin_out_reg <= 1'b0;
            rst_pin_dir_reg <= 1'b0;
        end else if (wr_en && idx_hit(aphase_reg.index, SLRC_IDX_PIN_CTRL)) begin
            port_out_reg <= hwdata[SLRC_PC_OUT_LSB +: PORT_WIDTH];
            port_dir_reg <= hwdata[SLRC_PC_DIR_LSB +: PORT_WIDTH];
            rst_pin_out_reg <= hwdata[SLRC_PC_RST_OUT];
            rst_pin_dir_reg <= hwdata[SLRC_PC_RST_DIR];
        end
    end

    // the io strap is caught once at the first edge after reset release, then frozen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_io_reg <= 1'b0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            rst_io_reg <= reset_pin_as_io;
            strap_done_reg <= 1'b1;
        end
    end

    // pin low counts as reset only while it serves as reset input
    assign rst_pin_low = !rst_io_reg && !reset_pin_in;

    // filter: a low shorter than the minimum pulse is dropped, a longer one raises the request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_cnt_reg <= '0;
            rst_req_reg <= 1'b0;
        end else if (!rst_pin_low) begin
            rst_cnt_reg <= '0;
            rst_req_reg <= 1'b0;
        end else if (rst_cnt_reg != RST_CNT_MAX) begin
            rst_cnt_reg <= rst_cnt_reg + 1'b1;
        end else begin
            rst_req_reg <= 1'b1;
        end
    end
    // hresetn itself is the clockless path; the filtered request is for a stopped-free clock
    assign chip_reset_req = rst_req_reg;

    // sleep sequencer: enter on the instruction with enable set, leave on an interrupt
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SLRC_ST_ACTIVE: begin
                if (sleep_instr && core_control_reg[SLRC_CC_SLEEP_EN]) begin
                    case (sleep_sel)
                        SLRC_SEL_IDLE: state_next = SLRC_ST_IDLE;
                        SLRC_SEL_NOISE: state_next = SLRC_ST_NOISE;
                        SLRC_SEL_DOWN: state_next = SLRC_ST_DOWN;
                        default: state_next = SLRC_ST_ACTIVE; // reserved code, no sleep
                    endcase
                end
            end
            SLRC_ST_IDLE, SLRC_ST_NOISE, SLRC_ST_DOWN: begin
                if (irq_pending) begin
                    state_next = SLRC_ST_ACTIVE;
                end
            end
            default: state_next = SLRC_ST_ACTIVE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= SLRC_ST_ACTIVE;
        end else if (rst_req_reg) begin
            state_reg <= SLRC_ST_ACTIVE; // a pin reset also ends power-down
        end else begin
            state_reg <= state_next;
        end
    end

    // run enables per state; interrupt logic stays alive to allow wake-up from every state
    always_comb begin
        run_gates = '{core_run: 1'b1, io_run: 1'b1, adc_run: 1'b1, timer_run: 1'b1, irq_run: 1'b1};
        case (state_reg)
            SLRC_ST_ACTIVE: begin
            end
            SLRC_ST_IDLE: begin
                run_gates.core_run = 1'b0;
            end
            SLRC_ST_NOISE: begin
                run_gates.core_run = 1'b0;
                run_gates.io_run = 1'b0;
                run_gates.timer_run = 1'b0;
            end
            SLRC_ST_DOWN: begin
                run_gates = '{core_run: 1'b0, io_run: 1'b0, adc_run: 1'b0, timer_run: 1'b0, irq_run: 1'b1};
            end
            default: begin
            end
        endcase
    end

    // tristate path is combinational so it acts even without a clock
    always_comb begin
        general_port_pins_out = port_out_reg;
        general_port_pins_oe = port_dir_reg;
        general_port_pins_pullup = ~port_dir_reg & port_out_reg & {PORT_WIDTH{!core_control_reg[SLRC_CC_PULLUP_OFF]}};
        if (!hresetn || rst_pin_low || rst_req_reg) begin
            general_port_pins_oe = '0;
            general_port_pins_pullup = '0;
        end
    end

    // reset pin as weak io only after the strap selects it; as reset input it keeps its pull-up
    assign reset_pin_out = rst_io_reg && rst_pin_out_reg;
    assign reset_pin_oe = rst_io_reg && rst_pin_dir_reg && hresetn;
    assign reset_pin_pullup = !rst_io_reg;
endmodule

// ### verilog/slrc_pkg.sv
// package with register map, field positions, timing and carrier types for the sleep and reset controller
package slrc_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] SLRC_IDX_RESET_CAUSE = 8'h34;
    localparam logic [7:0] SLRC_IDX_CORE_CTRL = 8'h35;
    localparam logic [7:0] SLRC_IDX_PIN_CTRL = 8'h3C;
    localparam logic [7:0] SLRC_IDX_SLEEP_STAT = 8'h3D;
    // core_control fields
    localparam int SLRC_CC_PULLUP_OFF = 6;
    localparam int SLRC_CC_SLEEP_EN = 5;
    localparam int SLRC_CC_SEL_HI = 4;
    localparam int SLRC_CC_SEL_LO = 3;
    localparam logic [7:0] SLRC_CC_WMASK = 8'h7B;
    localparam logic [7:0] SLRC_CC_RESET = 8'h00;
    // reset_cause_flags fields
    localparam int SLRC_RC_EXT = 1;
    localparam int SLRC_RC_POWER = 0;
    localparam logic [7:0] SLRC_RC_RESET = 8'h01;
    // pin control fields
    localparam int SLRC_PC_OUT_LSB = 0;
    localparam int SLRC_PC_DIR_LSB = 8;
    localparam int SLRC_PC_RST_OUT = 16;
    localparam int SLRC_PC_RST_DIR = 17;
    localparam int SLRC_PC_IN_LSB = 24;
    localparam int SLRC_PC_RST_IN = 30;
    localparam int SLRC_PC_RST_IO = 31;
    // sleep mode select encodings
    localparam logic [1:0] SLRC_SEL_IDLE = 2'h0;
    localparam logic [1:0] SLRC_SEL_NOISE = 2'h1;
    localparam logic [1:0] SLRC_SEL_DOWN = 2'h2;
    // timing
    localparam int SLRC_CLK_PERIOD_NS = 100;
    localparam int SLRC_RST_MIN_PULSE_NS = 2500;
    localparam int SLRC_RST_MIN_CYCLES = (SLRC_RST_MIN_PULSE_NS + SLRC_CLK_PERIOD_NS - 1) / SLRC_CLK_PERIOD_NS;
    localparam logic [1:0] SLRC_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        SLRC_ST_ACTIVE = 2'b00,
        SLRC_ST_IDLE = 2'b01,
        SLRC_ST_NOISE = 2'b10,
        SLRC_ST_DOWN = 2'b11
    } slrc_state_type;

    // clock domain run enables handed to the rest of the chip
    typedef struct packed {
        logic core_run;
        logic io_run;
        logic adc_run;
        logic timer_run;
        logic irq_run;
    } slrc_gate_type;

    // captured ahb address phase
    typedef struct packed {
        logic write;
        logic [7:0] index;
    } slrc_aphase_type;
endpackage

// ### dv/slrc_top_asserts.sv
// concurrent checks on the sleep and reset controller ports
`timescale 1ns/1ps
module slrc_checker import slrc_pkg::*; #(
    parameter int PORT_WIDTH = 6
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sleep_instr,
    input wire logic irq_pending,
    input wire logic reset_pin_as_io,
    input wire logic reset_pin_in,
    input wire logic reset_pin_oe,
    input wire logic chip_reset_req,
    input wire logic [PORT_WIDTH-1:0] general_port_pins_oe,
    input wire slrc_gate_type run_gates
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [5:0] low_cnt;
    // consecutive low samples of the pin while it acts as reset; saturates so it never wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            low_cnt <= 6'h00;
        else if (reset_pin_in || reset_pin_as_io)
            low_cnt <= 6'h00;
        else if (low_cnt != 6'h3F)
            low_cnt <= low_cnt + 6'h01;
    end
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    pin_tristate_a: assert property (!reset_pin_as_io && !reset_pin_in |-> general_port_pins_oe == '0)
        else $error("port driven while reset pin low");
    short_pulse_a: assert property (low_cnt != 6'h00 && low_cnt < 6'h14 |-> !chip_reset_req)
        else $error("short pulse caused reset");
    long_pulse_a: assert property (low_cnt >= 6'h1E |-> chip_reset_req) else $error("long pulse ignored");
    req_tristate_a: assert property (chip_reset_req |-> general_port_pins_oe == '0)
        else $error("port driven during reset");
    sleep_cause_a: assert property ($fell(run_gates.core_run) |-> $past(sleep_instr))
        else $error("core stopped without sleep");
    irq_wake_a: assert property (!run_gates.core_run && irq_pending |=> run_gates == 5'h1F)
        else $error("no wake on interrupt");
    gates_legal_a: assert property (run_gates inside {5'h1F, 5'h0F, 5'h05, 5'h01})
        else $error("illegal run gate pattern");
    io_pin_oe_a: assert property (!reset_pin_as_io |-> !reset_pin_oe) else $error("reset pin driven");
    cover property (!run_gates.core_run);
    cover property ($rose(chip_reset_req));
    cover property (reset_pin_oe);
endmodule
bind slrc_top slrc_checker #(.PORT_WIDTH(PORT_WIDTH)) i_checker (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_instr(sleep_instr), .irq_pending(irq_pending),
    .reset_pin_as_io(reset_pin_as_io), .reset_pin_in(reset_pin_in), .reset_pin_oe(reset_pin_oe),
    .chip_reset_req(chip_reset_req), .general_port_pins_oe(general_port_pins_oe), .run_gates(run_gates));

// ### dv/slrc_top_bench.sv
// self-checking bench for the sleep and reset controller
`timescale 1ns/1ps
module slrc_top_bench import slrc_pkg::*;;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, sleep_instr = 1'h0, irq_pending = 1'h0;
    logic strap = 1'h0, rpin_drv = 1'h1, rpin, hreadyout, hresp, rpo, rpoe, rppu, creq;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [5:0] gin = 6'h00, gout, goe, gpu;
    slrc_gate_type gates;
    int fails = 0, checks = 0, seed = 18, d;
    // register model kept from the rules, updated as writes land
    int cc_m = SLRC_CC_RESET, rc_m = SLRC_RC_RESET;
    logic [4:0] mode_gates [4] = '{5'h0F, 5'h05, 5'h01, 5'h1F};
    // reset pin wire level: device drive wins over the bench's weak source
    assign rpin = rpoe ? rpo : rpin_drv;
    slrc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sleep_instr(sleep_instr), .irq_pending(irq_pending),
        .reset_pin_as_io(strap), .reset_pin_in(rpin), .reset_pin_out(rpo), .reset_pin_oe(rpoe),
        .reset_pin_pullup(rppu), .chip_reset_req(creq), .general_port_pins_in(gin),
        .general_port_pins_out(gout), .general_port_pins_oe(goe), .general_port_pins_pullup(gpu),
        .run_gates(gates));
    initial forever #50 hclk = ~hclk;
    task complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for hready sampled high at a rising edge
    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'h1) begin
            if (++n > 50) begin
                fails++;
                complete_run;
            end
            @(posedge hclk);
        end
    endtask
    // one single-word transfer; the write data or read data sits in the data phase
    task xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'h1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= SLRC_HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
        if (w && idx == SLRC_IDX_CORE_CTRL) begin
            cc_m = wd & SLRC_CC_WMASK;
        end
        if (w && idx == SLRC_IDX_RESET_CAUSE) begin
            rc_m = rc_m & wd; // writing zero clears a flag
        end
    endtask
    // try a sleep with the given control value, check gates and state, then wake by interrupt
    task sleep_try(input logic [31:0] cc, input logic [4:0] gexp, input logic [31:0] st);
        xfer(1'h1, SLRC_IDX_CORE_CTRL, cc, q);
        sleep_instr <= 1'h1;
        @(posedge hclk);
        sleep_instr <= 1'h0;
        #1;
        check(32'(gates), 32'(gexp));
        xfer(1'h0, SLRC_IDX_SLEEP_STAT, '0, q);
        check(q & 32'h0000_0003, st);
        irq_pending <= 1'h1;
        @(posedge hclk);
        irq_pending <= 1'h0;
        #1;
        check(32'(gates), 32'h0000_001F);
    endtask
    task pin_low(input int n);
        rpin_drv <= 1'h0;
        repeat (n) @(posedge hclk);
        #1;
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        // reset values and an unmapped place
        xfer(1'h0, SLRC_IDX_RESET_CAUSE, '0, q);
        check(q, rc_m);
        xfer(1'h0, SLRC_IDX_CORE_CTRL, '0, q);
        check(q, cc_m);
        xfer(1'h1, 8'h30, 32'hFFFF_FFFF, q);
        xfer(1'h0, 8'h30, '0, q);
        check(q, 32'h0000_0000);
        d = $random(seed);
        xfer(1'h1, SLRC_IDX_CORE_CTRL, d, q);
        xfer(1'h0, SLRC_IDX_CORE_CTRL, '0, q);
        check(q, cc_m);
        // refused without enable, then every select code with enable
        sleep_try(32'h0000_0000, 5'h1F, 32'h0);
        for (int s = 0; s < 4; s++) begin
            sleep_try(32'h0000_0020 | (s << 3), mode_gates[s], (s == 3) ? 0 : s + 1);
        end
        // port pins follow the pin control register
        gin <= 6'($random(seed));
        d = $random(seed) & 32'h0000_3F3F;
        xfer(1'h1, SLRC_IDX_PIN_CTRL, d, q);
        xfer(1'h0, SLRC_IDX_PIN_CTRL, '0, q);
        check(q, d | {gin, 24'h0} | 32'h4000_0000);
        check(32'(goe), 32'(d[13:8]));
        check(32'(gout), 32'(d[5:0]));
        check(32'(gpu), 32'(~d[13:8] & d[5:0] & {6{!cc_m[SLRC_CC_PULLUP_OFF]}}));
        // the pull-up disable bit removes every general port pull-up
        xfer(1'h1, SLRC_IDX_CORE_CTRL, 32'h0000_0040, q);
        #1;
        check(32'(gpu), 32'h0);
        // short pulse tristates only; long pulse resets and flags it
        pin_low(10);
        check(32'(goe), 32'h0);
        check(32'(gpu), 32'h0);
        check(32'(creq), 32'h0);
        rpin_drv <= 1'h1;
        @(posedge hclk);
        pin_low(30);
        check(32'(creq), 32'h1);
        check(32'(goe), 32'h0);
        rpin_drv <= 1'h1;
        repeat (3) @(posedge hclk);
        xfer(1'h0, SLRC_IDX_RESET_CAUSE, '0, q);
        check(32'(q[SLRC_RC_EXT]), 32'h1);
        rc_m = rc_m | (1 << SLRC_RC_EXT);
        check(q, rc_m);
        xfer(1'h1, SLRC_IDX_RESET_CAUSE, '0, q);
        xfer(1'h0, SLRC_IDX_RESET_CAUSE, '0, q);
        check(q, rc_m);
        // reset pin strapped as a general line, driven low by the device
        hresetn <= 1'h0;
        strap <= 1'h1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        cc_m = SLRC_CC_RESET;
        rc_m = SLRC_RC_RESET;
        xfer(1'h0, SLRC_IDX_RESET_CAUSE, '0, q);
        check(q, rc_m);
        xfer(1'h1, SLRC_IDX_PIN_CTRL, 32'h0002_0000, q);
        pin_low(30);
        check({rpoe, rpo, rppu, creq}, 4'h8);
        complete_run;
    end
endmodule
